// *** hdl/cot_pkg.sv ***
// Constants and register map of the converter offset trim register bank
package cot_pkg;
  // Bus geometry
  localparam int AXI_AW  = 12;
  localparam int AXI_DW  = 32;
  localparam int TRIM_W  = 16;
  localparam int FIELD_W = 12;
  localparam int NUM_TRIM = 4;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_TRIM_CORE0_INPUT_B = 10'h08C;
  localparam logic [9:0] IDX_TRIM_CORE1_INPUT_A = 10'h08E;
  localparam logic [9:0] IDX_TRIM_CORE1_INPUT_B = 10'h090;
  localparam logic [9:0] IDX_TRIM_CORE2_INPUT_A = 10'h092;
  localparam logic [9:0] IDX_CAL_STATUS         = 10'h096;

  // Slots of the trim array, then the status slot and the no-match code of the address decode
  localparam int SLOT_C0_B = 0;
  localparam int SLOT_C1_A = 1;
  localparam int SLOT_C1_B = 2;
  localparam int SLOT_C2_A = 3;
  localparam int SLOT_STATUS = 4;
  localparam int SLOT_NONE   = 5;

  // Field layout of a trim register
  localparam int FIELD_LSB = 0;
  localparam int RSVD_LSB  = 12;
  localparam logic [3:0]  RSVD_RESET = 4'h0;
  localparam logic [11:0] FACTORY_TRIM_DEFAULT = 12'h800;

  // Calibration status register bits
  localparam int ST_FG_RUNNING   = 0;
  localparam int ST_BG_CAL_EN    = 1;
  localparam int ST_BG_OFS_EN    = 2;
  localparam int ST_FG_OFS_EN    = 3;
  localparam int ST_FOREGROUND_CAL_DONE_FLAG      = 4;
  localparam int ST_HALTED       = 5;
  localparam int ST_UNSAFE_WRITE = 6;
  localparam int ST_UNSAFE_READ  = 7;

  // Responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [FIELD_W-1:0] cot_field_t;
endpackage

// *** hdl/cot_regs.sv ***
// Offset trim register bank with AXI4-Lite access
// Behaviour
// - Core 0 uses its input-B trim value while it samples input B.
// - Core 1 uses its input-A trim on input A and its input-B trim on input B.
// - Each twelve-bit trim value is treated as unsigned, never sign-extended.
// - After reset each trim holds a factory value that software can read and overwrite.
// - Core 1 input-B trim sits at pair 0x090, bits 15:12 reserved RW reset zero.
// - Core 2 input-A trim sits at pair 0x092 with the same layout.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cot_regs
  import cot_pkg::*;
#(
  parameter logic [11:0] FACTORY_TRIM_C0_B = FACTORY_TRIM_DEFAULT,
  parameter logic [11:0] FACTORY_TRIM_C1_A = FACTORY_TRIM_DEFAULT,
  parameter logic [11:0] FACTORY_TRIM_C1_B = FACTORY_TRIM_DEFAULT,
  parameter logic [11:0] FACTORY_TRIM_C2_A = FACTORY_TRIM_DEFAULT
)
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  input  wire logic [AXI_AW-1:0] i_s_axi_awaddr,
  input  wire logic              i_s_axi_awvalid,
  output var  logic              o_s_axi_awready,
  input  wire logic [AXI_DW-1:0] i_s_axi_wdata,
  input  wire logic [3:0]        i_s_axi_wstrb,
  input  wire logic              i_s_axi_wvalid,
  output var  logic              o_s_axi_wready,
  output var  logic [1:0]        o_s_axi_bresp,
  output var  logic              o_s_axi_bvalid,
  input  wire logic              i_s_axi_bready,
  input  wire logic [AXI_AW-1:0] i_s_axi_araddr,
  input  wire logic              i_s_axi_arvalid,
  output var  logic              o_s_axi_arready,
  output var  logic [AXI_DW-1:0] o_s_axi_rdata,
  output var  logic [1:0]        o_s_axi_rresp,
  output var  logic              o_s_axi_rvalid,
  input  wire logic              i_s_axi_rready,
  input  wire logic              i_foreground_cal_running,
  input  wire logic              i_background_cal_enable,
  input  wire logic              i_background_offset_cal_enable,
  input  wire logic              i_foreground_offset_cal_enable,
  input  wire logic              i_foreground_cal_done_flag,
  input  wire logic              i_calibration_halted_flag,
  input  wire logic [2:0]        i_core_samples_input_b,
  input  wire cot_field_t        i_core0_trim_input_a,
  input  wire cot_field_t        i_core2_trim_input_b,
  output var  cot_field_t        o_core0_offset,
  output var  cot_field_t        o_core1_offset,
  output var  cot_field_t        o_core2_offset
);
  localparam logic [11:0] FACTORY [NUM_TRIM] =
    '{FACTORY_TRIM_C0_B, FACTORY_TRIM_C1_A, FACTORY_TRIM_C1_B, FACTORY_TRIM_C2_A};

  // Address decode shared by read and write paths
  function automatic logic [2:0] slot_of(input logic [AXI_AW-1:0] addr);
    logic [2:0] s;
    s = 3'(SLOT_NONE);
    if (addr[1:0] == 2'h0)
    begin
      case (addr[AXI_AW-1:2])
        IDX_TRIM_CORE0_INPUT_B: s = 3'(SLOT_C0_B);
        IDX_TRIM_CORE1_INPUT_A: s = 3'(SLOT_C1_A);
        IDX_TRIM_CORE1_INPUT_B: s = 3'(SLOT_C1_B);
        IDX_TRIM_CORE2_INPUT_A: s = 3'(SLOT_C2_A);
        IDX_CAL_STATUS:         s = 3'(SLOT_STATUS);
        default:                s = 3'(SLOT_NONE);
      endcase
    end
    return s;
  endfunction

  logic              rst_meta_q;
  logic              rst_sync_q;
  logic [TRIM_W-1:0] trim_q [NUM_TRIM];
  logic              aw_full_q;
  logic              w_full_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [AXI_DW-1:0] wdata_q;
  logic [3:0]        wstrb_q;
  logic              commit;
  logic [2:0]        wslot;
  logic [2:0]        rslot;
  logic              unsafe_write_q;
  logic              unsafe_read_q;
  logic              write_barred;
  logic              read_unsettled;
  logic              trim_read;
  logic [7:0]        status;

  // Reset release through two flops
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Write address and data are accepted independently
  assign o_s_axi_awready = !aw_full_q && !o_s_axi_bvalid;
  assign o_s_axi_wready  = !w_full_q && !o_s_axi_bvalid;
  assign commit          = aw_full_q && w_full_q && !o_s_axi_bvalid;
  assign wslot           = slot_of(awaddr_q);

  always_ff @(posedge i_ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      aw_full_q <= 1'b0;
      awaddr_q  <= '0;
    end
    else if (i_s_axi_awvalid && o_s_axi_awready)
    begin
      aw_full_q <= 1'b1;
      awaddr_q  <= i_s_axi_awaddr;
    end
    else if (commit)
    begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      w_full_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end
    else if (i_s_axi_wvalid && o_s_axi_wready)
    begin
      w_full_q <= 1'b1;
      wdata_q  <= i_s_axi_wdata;
      wstrb_q  <= i_s_axi_wstrb;
    end
    else if (commit)
    begin
      w_full_q <= 1'b0;
    end
  end

  // Write response, error on unmapped word
  always_ff @(posedge i_ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= RESP_OKAY;
    end
    else if (commit)
    begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp  <= (wslot == 3'(SLOT_NONE)) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (i_s_axi_bready)
    begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // Trim registers, one per slot, byte lanes map to byte addresses
  genvar g;
  generate
    for (g = 0; g < NUM_TRIM; g++)
    begin : g_trim
      always_ff @(posedge i_ref_clk or negedge rst_sync_q)
      begin
        if (!rst_sync_q)
        begin
          trim_q[g] <= {RSVD_RESET, FACTORY[g]};
        end
        else if (commit && wslot == 3'(g))
        begin
          if (wstrb_q[0])
          begin
            trim_q[g][7:0] <= wdata_q[7:0];
          end
          if (wstrb_q[1])
          begin
            trim_q[g][15:8] <= wdata_q[15:8];
          end
        end
      end
    end
  endgenerate

  // Hand the twelve-bit fields to the correction stage
  cot_trim_if trim_bus ();
  generate
    for (g = 0; g < NUM_TRIM; g++)
    begin : g_field
      assign trim_bus.trim[g] = trim_q[g][FIELD_W-1:0];
    end
  endgenerate

  cot_trim_apply u_cot_trim_apply (
    .i_ref_clk              (i_ref_clk),
    .i_rst_n                (rst_sync_q),
    .trims                  (trim_bus.apply),
    .i_core_samples_input_b (i_core_samples_input_b),
    .i_core0_trim_input_a   (i_core0_trim_input_a),
    .i_core2_trim_input_b   (i_core2_trim_input_b),
    .o_core0_offset         (o_core0_offset),
    .o_core1_offset         (o_core1_offset),
    .o_core2_offset         (o_core2_offset)
  );

  // Calibration conditions under which access is unsafe
  assign write_barred = i_foreground_cal_running ||
                        (i_background_cal_enable && i_background_offset_cal_enable);
  assign read_unsettled =
    (i_foreground_offset_cal_enable && !i_background_offset_cal_enable &&
     !i_foreground_cal_done_flag) ||
    (i_background_cal_enable && i_background_offset_cal_enable &&
     !i_calibration_halted_flag);
  assign rslot     = slot_of(i_s_axi_araddr);
  assign trim_read = i_s_axi_arvalid && o_s_axi_arready && rslot < 3'(NUM_TRIM);

  // Sticky hazard flags, a new event beats a write-one clear
  always_ff @(posedge i_ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      unsafe_write_q <= 1'b0;
      unsafe_read_q  <= 1'b0;
    end
    else
    begin
      if (commit && wslot < 3'(NUM_TRIM) && write_barred)
      begin
        unsafe_write_q <= 1'b1;
      end
      else if (commit && wslot == 3'(SLOT_STATUS) && wstrb_q[0] && wdata_q[ST_UNSAFE_WRITE])
      begin
        unsafe_write_q <= 1'b0;
      end
      if (trim_read && read_unsettled)
      begin
        unsafe_read_q <= 1'b1;
      end
      else if (commit && wslot == 3'(SLOT_STATUS) && wstrb_q[0] && wdata_q[ST_UNSAFE_READ])
      begin
        unsafe_read_q <= 1'b0;
      end
    end
  end

  // Status word, live calibration inputs and sticky flags
  always_comb
  begin
    status                  = '0;
    status[ST_FG_RUNNING]   = i_foreground_cal_running;
    status[ST_BG_CAL_EN]    = i_background_cal_enable;
    status[ST_BG_OFS_EN]    = i_background_offset_cal_enable;
    status[ST_FG_OFS_EN]    = i_foreground_offset_cal_enable;
    status[ST_FOREGROUND_CAL_DONE_FLAG]      = i_foreground_cal_done_flag;
    status[ST_HALTED]       = i_calibration_halted_flag;
    status[ST_UNSAFE_WRITE] = unsafe_write_q;
    status[ST_UNSAFE_READ]  = unsafe_read_q;
  end

  // Read channel, data one cycle after the address is taken
  assign o_s_axi_arready = !o_s_axi_rvalid;

  always_ff @(posedge i_ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= '0;
      o_s_axi_rresp  <= RESP_OKAY;
    end
    else if (i_s_axi_arvalid && o_s_axi_arready)
    begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp  <= RESP_OKAY;
      o_s_axi_rdata  <= '0;
      if (rslot < 3'(NUM_TRIM))
      begin
        o_s_axi_rdata <= {16'h0000, trim_q[rslot[1:0]]};
      end
      else if (rslot == 3'(SLOT_STATUS))
      begin
        o_s_axi_rdata <= {24'h000000, status};
      end
      else
      begin
        o_s_axi_rresp <= RESP_SLVERR;
      end
    end
    else if (i_s_axi_rready)
    begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

  a_low_lane_write: assert property (@(posedge i_ref_clk) disable iff (!rst_sync_q)
    commit && wslot == 3'(SLOT_C1_B) && wstrb_q[0]
      |=> trim_q[SLOT_C1_B][7:0] == $past(wdata_q[7:0]))
    else $error("low byte lane not stored");
  a_high_lane_keep: assert property (@(posedge i_ref_clk) disable iff (!rst_sync_q)
    commit && wslot == 3'(SLOT_C2_A) && !wstrb_q[1]
      |=> $stable(trim_q[SLOT_C2_A][15:8]))
    else $error("high byte changed without strobe");
  a_reserved_rw: assert property (@(posedge i_ref_clk) disable iff (!rst_sync_q)
    commit && wslot == 3'(SLOT_C1_B) && wstrb_q[1]
      |=> trim_q[SLOT_C1_B][15:12] == $past(wdata_q[15:12]))
    else $error("reserved bits not writable");
  a_read_data: assert property (@(posedge i_ref_clk) disable iff (!rst_sync_q)
    i_s_axi_arvalid && o_s_axi_arready && rslot == 3'(SLOT_C0_B)
      |=> o_s_axi_rvalid && o_s_axi_rdata == {16'h0000, $past(trim_q[SLOT_C0_B])})
    else $error("trim readback wrong");
  a_write_answer: assert property (@(posedge i_ref_clk) disable iff (!rst_sync_q)
    commit |=> o_s_axi_bvalid ##0 (o_s_axi_bresp == RESP_OKAY) == ($past(wslot) != 3'(SLOT_NONE)))
    else $error("write response wrong");
  a_unsafe_flag: assert property (@(posedge i_ref_clk) disable iff (!rst_sync_q)
    commit && wslot < 3'(NUM_TRIM) && i_background_cal_enable && i_background_offset_cal_enable
      |=> unsafe_write_q)
    else $error("barred write not flagged");
  a_bvalid_hold: assert property (@(posedge i_ref_clk) disable iff (!rst_sync_q)
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped early");
endmodule
`default_nettype wire

// *** hdl/cot_trim_apply.sv ***
// Selects the offset correction for each converter core from its input
`timescale 1ns/1ps
`default_nettype none
module cot_trim_apply
  import cot_pkg::*;
(
  input  wire logic   i_ref_clk,
  input  wire logic   i_rst_n,
  cot_trim_if.apply   trims,
  input  wire logic [2:0] i_core_samples_input_b,
  input  wire cot_field_t i_core0_trim_input_a,
  input  wire cot_field_t i_core2_trim_input_b,
  output var  cot_field_t o_core0_offset,
  output var  cot_field_t o_core1_offset,
  output var  cot_field_t o_core2_offset
);
  // Registered correction per core, unsigned value passed untouched
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_core0_offset <= '0;
      o_core1_offset <= '0;
      o_core2_offset <= '0;
    end
    else
    begin
      o_core0_offset <= i_core_samples_input_b[0] ? trims.trim[SLOT_C0_B]
                                                  : i_core0_trim_input_a;
      o_core1_offset <= i_core_samples_input_b[1] ? trims.trim[SLOT_C1_B]
                                                  : trims.trim[SLOT_C1_A];
      o_core2_offset <= i_core_samples_input_b[2] ? i_core2_trim_input_b
                                                  : trims.trim[SLOT_C2_A];
    end
  end

  a_core0_input_b: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_core_samples_input_b[0] |=> o_core0_offset == $past(trims.trim[SLOT_C0_B]))
    else $error("core 0 input B trim not applied");

  a_core1_pick: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    1'b1 |=> o_core1_offset == ($past(i_core_samples_input_b[1])
      ? $past(trims.trim[SLOT_C1_B]) : $past(trims.trim[SLOT_C1_A])))
    else $error("core 1 trim selection wrong");
endmodule
`default_nettype wire

// *** hdl/cot_trim_if.sv ***
// Trim values passed from the register bank to the correction stage
`timescale 1ns/1ps
`default_nettype none
interface cot_trim_if;
  import cot_pkg::*;
  cot_field_t trim [NUM_TRIM];
  modport bank (output trim);
  modport apply (input trim);
endinterface
`default_nettype wire

// *** verif/tb_cot_regs.sv ***
// Self-checking bench for the offset trim register bank
`timescale 1ns/1ps
`default_nettype none
module tb_cot_regs;
  import cot_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [AXI_AW-1:0] awaddr = '0;
  logic [AXI_AW-1:0] araddr = '0;
  logic [AXI_DW-1:0] wdata = '0;
  logic [AXI_DW-1:0] rdata;
  logic [3:0]        wstrb = '0;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic              fg_run = 1'b0, bg_en = 1'b0, bg_ofs = 1'b0;
  logic              fg_ofs = 1'b0, foreground_cal_done_flag = 1'b0, halted = 1'b0;
  logic [2:0]        sel = '0;
  cot_field_t        c0a = '0, c2b = '0, off0, off1, off2;
  logic [15:0]       model [NUM_TRIM];
  logic [11:0]       taddr [NUM_TRIM];
  logic [11:0]       stat_addr;
  logic [33:0]       exp_r [$];
  logic [1:0]        exp_b [$];
  int                seed, errors = 0, n_compared = 0, cycles = 0;

  cot_regs u_cot_regs (
    .i_ref_clk(clk), .i_rst_n(rst_n),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .i_foreground_cal_running(fg_run), .i_background_cal_enable(bg_en),
    .i_background_offset_cal_enable(bg_ofs), .i_foreground_offset_cal_enable(fg_ofs),
    .i_foreground_cal_done_flag(foreground_cal_done_flag), .i_calibration_halted_flag(halted),
    .i_core_samples_input_b(sel), .i_core0_trim_input_a(c0a),
    .i_core2_trim_input_b(c2b), .o_core0_offset(off0), .o_core1_offset(off1),
    .o_core2_offset(off2)
  );

  // Free-running 50 MHz clock
  always #10 clk = ~clk;

  // Compare one value against its expectation
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Print counts and verdict, then stop
  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  // Watch responses, match each against the oldest note
  always @(posedge clk)
  begin
    if (rvalid && rready)
      check({rresp, rdata}, exp_r.pop_front());
    if (bvalid && bready)
      check({32'h0, bresp}, {32'h0, exp_b.pop_front()});
  end

  // AXI4-Lite write, address and data offered together
  task automatic axi_write(input logic [11:0] a, input logic [31:0] v,
                           input logic [3:0] s, input logic [1:0] resp);
    @(posedge clk);
    exp_b.push_back(resp);
    awaddr  <= a;
    wdata   <= v;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  // AXI4-Lite read with expected {resp, data}
  task automatic axi_read(input logic [11:0] a, input logic [33:0] exp);
    @(posedge clk);
    exp_r.push_back(exp);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // Trim helpers keeping the reference copy up to date
  task automatic wr_trim(input int i, input logic [31:0] v, input logic [3:0] s);
    axi_write(taddr[i], v, s, RESP_OKAY);
    if (s[0])
      model[i][7:0] = v[7:0];
    if (s[1])
      model[i][15:8] = v[15:8];
  endtask

  task automatic rd_trim(input int i);
    axi_read(taddr[i], {RESP_OKAY, 16'h0, model[i]});
  endtask

  task automatic rd_stat(input logic [7:0] v);
    axi_read(stat_addr, {RESP_OKAY, 24'h0, v});
  endtask

  // Walk every input selection and compare the corrections
  task automatic check_offsets();
    for (int s = 0; s < 8; s++)
    begin
      @(posedge clk);
      sel <= 3'(s);
      c0a <= 12'($random(seed));
      c2b <= 12'($random(seed));
      repeat (3) @(posedge clk);
      check({22'h0, off0}, {22'h0, sel[0] ? model[0][11:0] : c0a});
      check({22'h0, off1}, {22'h0, sel[1] ? model[2][11:0] : model[1][11:0]});
      check({22'h0, off2}, {22'h0, sel[2] ? c2b : model[3][11:0]});
    end
  endtask

  // Main sequence
  initial
  begin
    seed = 46;
    taddr[0] = {IDX_TRIM_CORE0_INPUT_B, 2'b00};
    taddr[1] = {IDX_TRIM_CORE1_INPUT_A, 2'b00};
    taddr[2] = {IDX_TRIM_CORE1_INPUT_B, 2'b00};
    taddr[3] = {IDX_TRIM_CORE2_INPUT_A, 2'b00};
    stat_addr = {IDX_CAL_STATUS, 2'b00};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < NUM_TRIM; i++)
    begin
      model[i] = {RSVD_RESET, FACTORY_TRIM_DEFAULT};
      rd_trim(i);
    end
    check_offsets();
    $display("Test reset_values done");
    // Full-word writes, reserved bits included, back to back
    for (int r = 0; r < 2; r++)
    begin
      for (int i = 0; i < NUM_TRIM; i++)
        wr_trim(i, $random(seed), 4'hF);
      for (int i = 0; i < NUM_TRIM; i++)
        rd_trim(i);
      check_offsets();
    end
    $display("Test full_writes done");
    // Single byte lanes
    for (int i = 0; i < 2 * NUM_TRIM; i++)
    begin
      wr_trim(i % NUM_TRIM, $random(seed), (i < NUM_TRIM) ? 4'h1 : 4'h2);
      rd_trim(i % NUM_TRIM);
    end
    $display("Test byte_lanes done");
    // Unmapped and unaligned places leave the trims alone
    axi_write(12'h234, $random(seed), 4'hF, RESP_SLVERR);
    axi_write(12'h231, $random(seed), 4'hF, RESP_SLVERR);
    axi_read(12'h234, {RESP_SLVERR, 32'h0});
    for (int i = 0; i < NUM_TRIM; i++)
      rd_trim(i);
    $display("Test unmapped done");
    // Write during a foreground run is flagged
    fg_run <= 1'b1;
    wr_trim(0, $random(seed), 4'h3);
    rd_stat(8'h41);
    fg_run <= 1'b0;
    axi_write(stat_addr, 32'hC0, 4'h1, RESP_OKAY);
    rd_stat(8'h00);
    rd_trim(0);
    // Both background enables: writes flagged, reads only while halted
    bg_en  <= 1'b1;
    bg_ofs <= 1'b1;
    wr_trim(1, $random(seed), 4'h3);
    rd_trim(1);
    rd_stat(8'hC6);
    axi_write(stat_addr, 32'hC0, 4'h1, RESP_OKAY);
    halted <= 1'b1;
    rd_trim(1);
    rd_stat(8'h26);
    // Foreground offset cal without background: reads wait for done
    bg_en  <= 1'b0;
    bg_ofs <= 1'b0;
    halted <= 1'b0;
    fg_ofs <= 1'b1;
    rd_trim(2);
    rd_stat(8'h88);
    axi_write(stat_addr, 32'h80, 4'h1, RESP_OKAY);
    foreground_cal_done_flag <= 1'b1;
    rd_trim(2);
    rd_stat(8'h18);
    check_offsets();
    $display("Test cal_gating done");
    // Sticky flag set, then a mid-run reset restores trims and clears flags
    fg_run <= 1'b1;
    wr_trim(3, $random(seed), 4'h3);
    fg_run <= 1'b0;
    rd_stat(8'h58);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < NUM_TRIM; i++)
    begin
      model[i] = {RSVD_RESET, FACTORY_TRIM_DEFAULT};
      rd_trim(i);
    end
    rd_stat(8'h18);
    check_offsets();
    $display("Test mid_reset done");
    repeat (2) @(posedge clk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
